// ===== bench/tb_urbs_rx_status.sv
/*
  Self-checking testbench of the receive break and FIFO error block.
  Assumes default parameters: depth 8, DMA level 5.
*/
`include "urbs_cfg.svh"

module tb_urbs_rx_status;
  timeunit 1ns;
  timeprecision 1ns;
  import urbs_pkg::*;

  logic       clock;
  logic       rst;
  logic       clk_en;
  logic       rx_pin;
  logic       char_valid;
  urbs_byte_t char_data;
  logic       c_par;
  logic       c_frm;
  logic       c_aux;
  logic       c_nul;
  urbs_byte_t reg_addr;
  urbs_byte_t reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  urbs_byte_t reg_rdata;
  logic       dma_rx_req;
  logic       break_irq;
  logic       fifo_err_irq;
  urbs_byte_t v;
  int         n_mismatch;
  int         check_count;

  always #10 clock = ~clock;

  urbs_rx_status dut_u (
    .clock(clock), .rst(rst), .clk_en(clk_en), .rx_pin(rx_pin),
    .char_valid(char_valid), .char_data(char_data),
    .char_parity_err(c_par), .char_frame_err(c_frm),
    .char_aux_err(c_aux), .char_null_break(c_nul),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_rx_req(dma_rx_req),
    .break_irq(break_irq), .fifo_err_irq(fifo_err_irq)
  );

  urbs_rx_partner p_u (
    .clock(clock), .rx_pin(rx_pin), .char_valid(char_valid),
    .char_data(char_data), .char_parity_err(c_par),
    .char_frame_err(c_frm), .char_aux_err(c_aux),
    .char_null_break(c_nul)
  );

  // ----------------------------------------------------------------
  // Register access and comparison
  // ----------------------------------------------------------------
  task automatic wr(input urbs_byte_t a, d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input urbs_byte_t a, output urbs_byte_t d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input string nm, input urbs_byte_t got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic flags(input urbs_byte_t exp);
    #1 chk("outs", {5'h00, dma_rx_req, break_irq, fifo_err_irq}, exp);
  endtask

  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    {n_mismatch, check_count} = '0;
    {clock, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    clk_en = 1'b1;
    rst = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    flags(8'h00);
    rd(`URBS_OFF_STAT0, v);
    chk("stat0", v, 8'h00);
    rd(`URBS_OFF_CTRL, v);
    chk("ctrl", v, 8'h01);
    rd(8'hF0, v);
    chk("unmapped", v, 8'h00);
    // Break with null character
    p_u.line(1'b0);
    p_u.send(8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
    flags(8'h03);
    rd(`URBS_OFF_STAT0, v);
    chk("stat0", v, 8'h28);
    rd(`URBS_OFF_STAT1, v);
    chk("stat1", v, 8'h12);
    p_u.send(8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
    p_u.line(1'b1);
    repeat (6) @(posedge clock);
    rd(`URBS_OFF_STAT0, v);
    chk("stat0", v, 8'h38);
    p_u.send(8'h5A, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(`URBS_OFF_DATA, v);
    chk("data", v, 8'h00);
    rd(`URBS_OFF_STAT0, v);
    chk("stat0", v, 8'h18);
    rd(`URBS_OFF_DATA, v);
    chk("data", v, 8'h5A);
    wr(`URBS_OFF_STAT0, 8'h18);
    // Second break: detection re-armed, bit 5 not writable
    p_u.line(1'b0);
    p_u.send(8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(`URBS_OFF_STAT0, 8'h20);
    rd(`URBS_OFF_STAT0, v);
    chk("stat0", v, 8'h28);
    p_u.line(1'b1);
    repeat (6) @(posedge clock);
    wr(`URBS_OFF_STAT0, 8'h18);
    rd(`URBS_OFF_DATA, v);
    chk("data", v, 8'h00);
    rd(`URBS_OFF_STAT0, v);
    chk("stat0", v, 8'h00);
    // Error tag outside, then inside, the bottom four entries
    for (int i = 0; i < 8; i++) begin
      p_u.send(8'h10 + i[7:0], 1'b0, 1'b0, i == 4, 1'b0);
    end
    flags(8'h04);
    rd(`URBS_OFF_DATA, v);
    chk("data", v, 8'h10);
    flags(8'h01);
    for (int i = 1; i < 8; i++) begin
      rd(`URBS_OFF_DATA, v);
      chk("data", v, 8'h10 + i[7:0]);
    end
    flags(8'h00);
    p_u.send(8'hC3, 1'b1, 1'b0, 1'b0, 1'b0);
    flags(8'h01);
    rd(`URBS_OFF_STAT1, v);
    chk("stat1", v, 8'h0A);
    rd(`URBS_OFF_DATA, v);
    chk("data", v, 8'hC3);
    // Overrun: a ninth character finds the FIFO full
    for (int i = 0; i < 9; i++) begin
      p_u.send(8'h20 + i[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
    end
    rd(`URBS_OFF_STAT1, v);
    chk("stat1", v, 8'h22);
    wr(`URBS_OFF_STAT1, 8'h20);
    rd(`URBS_OFF_STAT1, v);
    chk("stat1", v, 8'h02);
    for (int i = 0; i < 8; i++) begin
      rd(`URBS_OFF_DATA, v);
      chk("data", v, 8'h20 + i[7:0]);
    end
    // Receive disabled drops characters; clock enable low freezes writes
    wr(`URBS_OFF_CTRL, 8'h00);
    p_u.send(8'h77, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(`URBS_OFF_STAT1, v);
    chk("stat1", v, 8'h00);
    @(posedge clock) clk_en <= 1'b0;
    wr(`URBS_OFF_CTRL, 8'h01);
    @(posedge clock) clk_en <= 1'b1;
    rd(`URBS_OFF_CTRL, v);
    chk("ctrl", v, 8'h00);
    // Reset in mid-run restores the control reset value
    @(posedge clock) rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    flags(8'h00);
    rd(`URBS_OFF_CTRL, v);
    chk("ctrl", v, 8'h01);
    stop_test();
  end
endmodule

// ===== bench/urbs_rx_partner.sv
/*
  Remote serial transmitter model: drives the receive pin and hands
  characters to the block as the receive shifter would.
  Assumes the block samples characters on the rising clock edge.
*/
module urbs_rx_partner (
  input  wire logic                 clock,
  output logic                      rx_pin,
  output logic                      char_valid,
  output urbs_pkg::urbs_byte_t      char_data,
  output logic                      char_parity_err,
  output logic                      char_frame_err,
  output logic                      char_aux_err,
  output logic                      char_null_break
);
  timeunit 1ns;
  timeprecision 1ns;
  import urbs_pkg::*;

  initial begin
    rx_pin = 1'b1;
    char_valid = 1'b0;
    char_data = 8'h00;
    {char_parity_err, char_frame_err, char_aux_err} = 3'h0;
    char_null_break = 1'b0;
  end

  // Line level; held low for a break
  task automatic line(input logic lvl);
    @(posedge clock);
    rx_pin <= lvl;
  endtask

  // One character pulse; data inverted once released
  task automatic send(input urbs_byte_t d, input logic p, f, a, n);
    @(posedge clock);
    char_valid <= 1'b1;
    char_data <= d;
    char_parity_err <= p;
    char_frame_err <= f;
    char_aux_err <= a;
    char_null_break <= n;
    @(posedge clock);
    char_valid <= 1'b0;
    char_data <= ~d;
  endtask
endmodule

// ===== rtl/urbs_rx_status.sv
/*
  Receive FIFO with error tags, break begin and end tracking, the
  error-in-FIFO flag and the gating of receive DMA requests.
  Assumes a receive shifter on the same clock that offers one
  character per pulse, and a register master on the same clock.
*/
`include "urbs_cfg.svh"

// How it works
// - Break end flag sets on a receive pin rise once break begin is latched.
// - Setting break end re-arms break begin detection; the flags alternate.
// - Setting break end lets received characters enter the FIFO again.
// - Error-in-FIFO sits at status bit 5, read-only, derived from FIFO.
// - No tag bit 8..10 in bottom four entries: flag clear, DMA enabled.
// - Any tag bit 8..10 in bottom four entries sets flag, requests irq.
// - While error-in-FIFO is set, receive DMA requests are held off.
// - All-zero null character sets break begin and requests an interrupt.
// - Only the first all-zero null is stored; later ones dropped until end.
// - Tag bit 8 marks a parity error and travels with its byte.
// - Tag bit 9 marks a framing error and travels with its byte.
module urbs_rx_status #(
  parameter int DEPTH     = `URBS_FIFO_DEPTH,
  parameter int DMA_LEVEL = `URBS_DMA_LEVEL
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic          rx_pin,
  input  wire logic          char_valid,
  input  wire urbs_pkg::urbs_byte_t char_data,
  input  wire logic          char_parity_err,
  input  wire logic          char_frame_err,
  input  wire logic          char_aux_err,
  input  wire logic          char_null_break,
  input  wire urbs_pkg::urbs_byte_t reg_addr,
  input  wire urbs_pkg::urbs_byte_t reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output urbs_pkg::urbs_byte_t reg_rdata,
  output logic               dma_rx_req,
  output logic               break_irq,
  output logic               fifo_err_irq
);
  import urbs_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int EW = `URBS_ENTRY_W;

  // ----------------------------------------------------------------
  // Size check
  // ----------------------------------------------------------------
  if (DEPTH < `URBS_BOTTOM_N || (DEPTH & (DEPTH - 1)) != 0 ||
      DMA_LEVEL < 1 || DMA_LEVEL > DEPTH) begin : g_bad
    $error("urbs_rx_status: unsupported DEPTH or DMA_LEVEL");
  end

  typedef struct packed {
    logic [DEPTH-1:0][EW-1:0] mem;
    logic [PW-1:0]            wr_ptr;
    logic [PW-1:0]            rd_ptr;
    logic [PW:0]              count;
    urbs_brk_t                brk;
    logic                     brk_begin;
    logic                     brk_end;
    logic                     fifo_error_flag;
    logic                     ror;
    logic                     rx_prev;
    urbs_byte_t               ctrl;
    urbs_byte_t               rdata;
  } urbs_st_t;

  urbs_st_t q;
  urbs_st_t d;
  logic     rx_s;
  logic     rise;
  logic     store_ok;
  logic     push;
  logic     pop;
  logic     full;
  logic     clr_begin;
  logic     clr_end;

  // ----------------------------------------------------------------
  // Tag scan over the bottom entries
  // ----------------------------------------------------------------
  function automatic logic bottom_err(input urbs_st_t s);
    logic          any;
    logic [PW-1:0] idx;
    any = 1'b0;
    for (int i = 0; i < `URBS_BOTTOM_N; i++) begin
      idx = PW'(s.rd_ptr + PW'(i));
      if ((PW+1)'(i) < s.count) begin
        any = any | (|s.mem[idx][`URBS_TAG_HI:`URBS_TAG_LO]);
      end
    end
    return any;
  endfunction

  urbs_sync u_rx_sync (
    .clock  (clock),
    .rst    (rst),
    .clk_en (clk_en),
    .din    (rx_pin),
    .dout   (rx_s)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.rdata   = '0;
    d.rx_prev = rx_s;
    rise      = rx_s & ~q.rx_prev;
    store_ok  = 1'b0;
    clr_begin = reg_wr && reg_addr == `URBS_OFF_STAT0 &&
                reg_wdata[`URBS_BIT_BEGIN];
    clr_end   = reg_wr && reg_addr == `URBS_OFF_STAT0 &&
                reg_wdata[`URBS_BIT_END];
    d.brk_begin = q.brk_begin & ~clr_begin;
    d.brk_end   = q.brk_end & ~clr_end;
    case (q.brk)
      URBS_ARMED: begin
        store_ok = char_valid;
        if (char_valid && char_null_break) begin
          d.brk_begin = 1'b1;
          d.brk       = URBS_IN_BREAK;
        end
      end
      URBS_IN_BREAK: begin
        store_ok = 1'b0;
        if (rise) begin
          d.brk_end = 1'b1;
          d.brk     = URBS_ARMED;
        end
      end
      default: begin
        d.brk = URBS_ARMED;
      end
    endcase
    full = q.count == (PW+1)'(DEPTH);
    pop  = reg_rd && reg_addr == `URBS_OFF_DATA && q.count != '0;
    push = store_ok && q.ctrl[`URBS_CTRL_RXEN] && (!full || pop);
    if (reg_wr && reg_addr == `URBS_OFF_STAT1 &&
        reg_wdata[`URBS_S1_ROR]) begin
      d.ror = 1'b0;
    end
    if (store_ok && q.ctrl[`URBS_CTRL_RXEN] && full && !pop) begin
      d.ror = 1'b1;
    end
    if (push) begin
      d.mem[q.wr_ptr] = {char_aux_err, char_frame_err,
                         char_parity_err, char_data};
      d.wr_ptr        = PW'(q.wr_ptr + 1'b1);
    end
    if (pop) begin
      d.rd_ptr = PW'(q.rd_ptr + 1'b1);
    end
    d.count = (PW+1)'(q.count + push - pop);
    d.fifo_error_flag   = bottom_err(d);
    if (reg_wr && reg_addr == `URBS_OFF_CTRL) begin
      d.ctrl = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        `URBS_OFF_STAT0: begin
          d.rdata[`URBS_BIT_BEGIN] = q.brk_begin;
          d.rdata[`URBS_BIT_END]   = q.brk_end;
          d.rdata[`URBS_BIT_EIF]   = q.fifo_error_flag;
        end
        `URBS_OFF_DATA: begin
          d.rdata = q.mem[q.rd_ptr][7:0];
        end
        `URBS_OFF_STAT1: begin
          d.rdata[`URBS_S1_RNE] = q.count != '0;
          d.rdata[`URBS_S1_PRE] = q.count != '0 &&
                                  q.mem[q.rd_ptr][`URBS_TAG_PAR];
          d.rdata[`URBS_S1_FRE] = q.count != '0 &&
                                  q.mem[q.rd_ptr][`URBS_TAG_FRM];
          d.rdata[`URBS_S1_ROR] = q.ror;
        end
        `URBS_OFF_CTRL: begin
          d.rdata = q.ctrl;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
    if (!clk_en) begin
      d = q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.brk     <= URBS_ARMED;
      q.ctrl    <= `URBS_CTRL_RST;
      q.rx_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata    = q.rdata;
  assign dma_rx_req   = q.count >= (PW+1)'(DMA_LEVEL) && !q.fifo_error_flag;
  assign break_irq    = q.brk_begin | q.brk_end;
  assign fifo_err_irq = q.fifo_error_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_null_armed;
    clk_en && q.brk == URBS_ARMED && char_valid && char_null_break;
  endsequence

  sequence s_break_entered;
    q.brk_begin && q.brk == URBS_IN_BREAK && break_irq;
  endsequence

  a_end_after_begin: assert property (
    $rose(q.brk_end) |-> $past(q.brk == URBS_IN_BREAK) && $past(rise))
    else $error("break end set without a latched break begin");

  a_end_rearms: assert property (
    $rose(q.brk_end) |-> q.brk == URBS_ARMED && break_irq)
    else $error("break end did not re-arm break begin");

  a_store_resumes: assert property (
    (clk_en && q.brk == URBS_ARMED && char_valid && !full && !pop &&
     q.ctrl[`URBS_CTRL_RXEN]) |=> q.count == $past(q.count) + 1'b1)
    else $error("character not stored while armed");

  a_eif_readback: assert property (
    (clk_en && reg_rd && reg_addr == `URBS_OFF_STAT0)
    |=> reg_rdata[`URBS_BIT_EIF] == $past(q.fifo_error_flag))
    else $error("error-in-FIFO bit reads wrong");

  a_eif_matches: assert property (
    q.fifo_error_flag == bottom_err(q))
    else $error("error-in-FIFO flag differs from bottom tags");

  a_eif_irq: assert property (
    q.fifo_error_flag |-> fifo_err_irq)
    else $error("error-in-FIFO without interrupt request");

  a_dma_gated: assert property (
    q.fifo_error_flag |-> !dma_rx_req)
    else $error("DMA request while error-in-FIFO set");

  a_begin_sets: assert property (s_null_armed |=> s_break_entered)
    else $error("null character did not set break begin");

  a_break_drops: assert property (
    (clk_en && q.brk == URBS_IN_BREAK && char_valid)
    |=> q.count <= $past(q.count))
    else $error("character stored during break");

  a_parity_tag: assert property (
    (clk_en && push && char_parity_err)
    |=> q.mem[$past(q.wr_ptr)][`URBS_TAG_PAR])
    else $error("parity tag not stored");

  a_frame_tag: assert property (
    (clk_en && push && char_frame_err)
    |=> q.mem[$past(q.wr_ptr)][`URBS_TAG_FRM])
    else $error("framing tag not stored");

endmodule

// ===== rtl/urbs_sync.sv
/*
  Two flip-flop synchroniser for the serial receive pin.
  Assumes the pin idles high; it resets to the idle level.
*/
module urbs_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic din,
  output logic      dout
);
  import urbs_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } urbs_sync_st_t;

  urbs_sync_st_t q;
  urbs_sync_st_t d;

  always_comb begin
    d = q;
    if (clk_en) begin
      d.s1 = din;
      d.s2 = q.s1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule

// ===== shared/urbs_cfg.svh
/*
  Offsets, field positions, reset values and default sizes of the
  receive break and FIFO error status block.
  Assumes an 8-bit register port with byte offsets.
*/
`ifndef URBS_CFG_SVH
`define URBS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define URBS_OFF_STAT0   8'h00
`define URBS_OFF_DATA    8'h04
`define URBS_OFF_STAT1   8'h08
`define URBS_OFF_CTRL    8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define URBS_BIT_BEGIN   3
`define URBS_BIT_END     4
`define URBS_BIT_EIF     5
`define URBS_S1_RNE      1
`define URBS_S1_PRE      3
`define URBS_S1_FRE      4
`define URBS_S1_ROR      5
`define URBS_CTRL_RXEN   0
`define URBS_TAG_PAR     8
`define URBS_TAG_FRM     9
`define URBS_TAG_AUX     10
`define URBS_TAG_LO      8
`define URBS_TAG_HI      10

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define URBS_CTRL_RST    8'h01
`define URBS_FIFO_DEPTH  8
`define URBS_DMA_LEVEL   5
`define URBS_BOTTOM_N    4
`define URBS_ENTRY_W     11

`endif

// ===== shared/urbs_pkg.sv
/*
  Types of the receive break and FIFO error status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package urbs_pkg;

  typedef logic [7:0] urbs_byte_t;

  // ----------------------------------------------------------------
  // Break tracking states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    URBS_ARMED    = 2'b01,
    URBS_IN_BREAK = 2'b10
  } urbs_brk_t;

endpackage
